/* rtl/fws_pkg.sv */
// constants, carriers and state layout of the flash status poller
package fws_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_ACC_NS = 90;
    localparam int T_WP_NS = 35;
    localparam int T_REC_NS = 30;
    localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;

    // ****************************************
    // commands
    // ****************************************
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_POLL_DATA = 3'h3;
    localparam logic [2:0] CMD_POLL_TOGGLE = 3'h4;

    // ****************************************
    // flash data bit positions
    // ****************************************
    localparam int DQ_POLL = 7;
    localparam int DQ_TGL1 = 6;
    localparam int DQ_TLIM = 5;
    localparam int DQ_EWIN = 3;
    localparam int DQ_TGL2 = 2;

    // ****************************************
    // status register bits
    // ****************************************
    localparam int SB_BUSY = 0;
    localparam int SB_DONE = 1;
    localparam int SB_FAIL = 2;
    localparam int SB_TGL1 = 3;
    localparam int SB_TGL2 = 4;
    localparam int SB_TLIM = 5;
    localparam int SB_EWIN = 6;
    localparam int SB_RB = 7;
    localparam int SB_SUSP = 8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } fws_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } fws_wb_rsp_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [7:0] dq;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fws_flash_out_t;

    typedef struct packed {
        logic [7:0] dq;
        logic ready_busy_n;
    } fws_flash_in_t;

    // ****************************************
    // controller state
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_RECOVER,
        PH_EVAL
    } fws_phase_t;

    typedef struct packed {
        fws_phase_t ph;
        logic [3:0] cnt;
        logic [2:0] cmd;
        logic [21:0] addr;
        logic [7:0] wdata;
        logic [7:0] sample;
        logic [7:0] prev;
        logic [7:0] rdata;
        logic first;
        logic confirm;
        logic retry;
        logic busy;
        logic done;
        logic fail;
        logic tgl1;
        logic tgl2;
        logic rb;
        fws_flash_out_t pin;
        fws_wb_rsp_t wb;
    } fws_state_t;

    localparam fws_flash_out_t PIN_RESET = '{addr: 22'h0, dq: 8'h00, dq_oe_n: 1'b1,
                                            ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    localparam fws_wb_rsp_t WB_RESET = '{ack: 1'b0, dat: 32'h0};
    localparam fws_state_t STATE_RESET = '{ph: PH_IDLE, cnt: 4'h0, cmd: CMD_NONE,
        addr: 22'h0, wdata: 8'h00, sample: 8'h00, prev: 8'h00, rdata: 8'h00,
        first: 1'b0, confirm: 1'b0, retry: 1'b0, busy: 1'b0, done: 1'b0, fail: 1'b0,
        tgl1: 1'b0, tgl2: 1'b0, rb: 1'b1, pin: PIN_RESET, wb: WB_RESET};

endpackage : fws_pkg

/* rtl/fws_poller.sv */
// host controller: drives flash pins, polls write status, wishbone slave
// Functional notes
// - host polls bit 7 at programmed address
// - host polls bit 7 inside erased sector
// - after bit 7 true, use next read
// - host combines both toggle bits for mode
// - host reads twice and compares toggle bits
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
module fws_poller (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire fws_pkg::fws_wb_req_t wb_req_i,
    output fws_pkg::fws_wb_rsp_t wb_rsp_o,
    // flash pins
    input wire fws_pkg::fws_flash_in_t flash_i,
    output fws_pkg::fws_flash_out_t flash_o
);
    import fws_pkg::*;

    fws_state_t s;
    fws_state_t next_s;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                              input logic en);
        merge_byte = en ? nw : old;
    endfunction : merge_byte

    function automatic logic [31:0] read_word(input fws_state_t st, input logic [7:0] adr);
        logic [31:0] w;
        w = 32'h0;
        case (adr)
            REG_CTRL: begin
                w[2:0] = st.cmd;
            end
            REG_ADDR: begin
                w[21:0] = st.addr;
            end
            REG_WDATA: begin
                w[7:0] = st.wdata;
            end
            REG_STATUS: begin
                w[SB_BUSY] = st.busy;
                w[SB_DONE] = st.done;
                w[SB_FAIL] = st.fail;
                w[SB_TGL1] = st.tgl1;
                w[SB_TGL2] = st.tgl2;
                w[SB_TLIM] = st.sample[DQ_TLIM];
                w[SB_EWIN] = st.sample[DQ_EWIN];
                w[SB_RB] = st.rb;
                w[SB_SUSP] = st.tgl2 & ~st.tgl1;
            end
            REG_RDATA: begin
                w[7:0] = st.rdata;
            end
            default: begin
                w = 32'h0;
            end
        endcase
        read_word = w;
    endfunction : read_word

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic req;
        logic [7:0] d;
        logic [7:0] diff;
        logic again;
        req = 1'b0;
        d = 8'h00;
        diff = 8'h00;
        again = 1'b0;
        next_s = s;
        // ready/busy pin, open drain, sampled each cycle
        next_s.rb = flash_i.ready_busy_n;

        // wishbone slave: ack one cycle after the strobe, dropped next cycle
        req = wb_req_i.cyc & wb_req_i.stb & ~s.wb.ack;
        next_s.wb.ack = req;
        next_s.wb.dat = req ? read_word(s, wb_req_i.adr) : 32'h0;
        if (req && wb_req_i.we && !s.busy) begin
            case (wb_req_i.adr)
                REG_ADDR: begin
                    next_s.addr[7:0] = merge_byte(s.addr[7:0], wb_req_i.dat[7:0],
                                                  wb_req_i.sel[0]);
                    next_s.addr[15:8] = merge_byte(s.addr[15:8], wb_req_i.dat[15:8],
                                                   wb_req_i.sel[1]);
                    if (wb_req_i.sel[2]) begin
                        next_s.addr[21:16] = wb_req_i.dat[21:16];
                    end
                end
                REG_WDATA: begin
                    next_s.wdata = merge_byte(s.wdata, wb_req_i.dat[7:0], wb_req_i.sel[0]);
                end
                REG_CTRL: begin
                    if (wb_req_i.sel[0] && wb_req_i.dat[2:0] != CMD_NONE) begin
                        next_s.cmd = wb_req_i.dat[2:0];
                        next_s.busy = 1'b1;
                        next_s.done = 1'b0;
                        next_s.fail = 1'b0;
                        next_s.first = 1'b1;
                        next_s.confirm = 1'b0;
                        next_s.retry = 1'b0;
                        next_s.tgl1 = 1'b0;
                        next_s.tgl2 = 1'b0;
                        next_s.ph = PH_SETUP;
                    end
                end
                default: begin
                end
            endcase
        end

        // flash access sequencer
        case (s.ph)
            PH_IDLE: begin
                next_s.pin.ce_n = 1'b1;
            end
            PH_SETUP: begin
                next_s.pin.addr = s.addr;
                next_s.pin.ce_n = 1'b0;
                next_s.pin.dq = s.wdata;
                next_s.pin.dq_oe_n = (s.cmd == CMD_WRITE) ? 1'b0 : 1'b1;
                next_s.cnt = 4'h0;
                next_s.ph = PH_STROBE;
            end
            PH_STROBE: begin
                // one strobe per access so each read counts once
                if (s.cmd == CMD_WRITE) begin
                    next_s.pin.we_n = 1'b0;
                end else begin
                    next_s.pin.oe_n = 1'b0;
                end
                next_s.cnt = s.cnt + 4'h1;
                if ((s.cmd == CMD_WRITE && s.cnt == WP_CYC) ||
                    (s.cmd != CMD_WRITE && s.cnt == ACC_CYC)) begin
                    next_s.sample = flash_i.dq;
                    next_s.pin.we_n = 1'b1;
                    next_s.pin.oe_n = 1'b1;
                    next_s.cnt = 4'h0;
                    next_s.ph = PH_RECOVER;
                end
            end
            PH_RECOVER: begin
                next_s.pin.ce_n = 1'b1;
                next_s.pin.dq_oe_n = 1'b1;
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == REC_CYC) begin
                    next_s.cnt = 4'h0;
                    next_s.ph = PH_EVAL;
                end
            end
            PH_EVAL: begin
                d = s.sample;
                diff = d ^ s.prev;
                next_s.prev = d;
                next_s.first = 1'b0;
                again = 1'b0;
                case (s.cmd)
                    CMD_WRITE: begin
                        // status valid from the end of this strobe
                        next_s.done = 1'b1;
                    end
                    CMD_READ: begin
                        next_s.rdata = d;
                        next_s.done = 1'b1;
                    end
                    CMD_POLL_DATA: begin
                        if (s.confirm) begin
                            // data from the read after bit 7 went true
                            next_s.rdata = d;
                            next_s.done = 1'b1;
                        end else if (d[DQ_POLL] == s.wdata[DQ_POLL]) begin
                            next_s.confirm = 1'b1;
                            again = 1'b1;
                        end else if (s.retry) begin
                            next_s.fail = 1'b1;
                            next_s.done = 1'b1;
                        end else begin
                            next_s.retry = d[DQ_TLIM];
                            again = 1'b1;
                        end
                    end
                    CMD_POLL_TOGGLE: begin
                        if (s.first) begin
                            again = 1'b1;
                        end else if (s.confirm) begin
                            next_s.rdata = d;
                            next_s.done = 1'b1;
                        end else begin
                            next_s.tgl1 = diff[DQ_TGL1];
                            next_s.tgl2 = diff[DQ_TGL2];
                            if (!diff[DQ_TGL1]) begin
                                // stopped: finished or erase suspended
                                next_s.confirm = 1'b1;
                                again = 1'b1;
                            end else if (s.retry) begin
                                next_s.fail = 1'b1;
                                next_s.done = 1'b1;
                            end else begin
                                next_s.retry = d[DQ_TLIM];
                                again = 1'b1;
                            end
                        end
                    end
                    default: begin
                        next_s.done = 1'b1;
                    end
                endcase
                if (again) begin
                    next_s.ph = PH_SETUP;
                end else begin
                    next_s.busy = 1'b0;
                    next_s.ph = PH_IDLE;
                end
            end
            default: begin
                next_s.ph = PH_IDLE;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_rsp_o = s.wb;
    assign flash_o = s.pin;

endmodule : fws_poller

/* sim/fws_poller_sva.sv */
// assertions on the poller ports
`timescale 1ns/1ns
module fws_poller_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire fws_pkg::fws_wb_req_t wb_req_i,
    input wire fws_pkg::fws_wb_rsp_t wb_rsp_o,
    input wire fws_pkg::fws_flash_in_t flash_i,
    input wire fws_pkg::fws_flash_out_t flash_o
);
    import fws_pkg::*;
    // ****
    // checks
    // ****
    logic req;
    assign req = wb_req_i.cyc && wb_req_i.stb;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; req && !wb_rsp_o.ack |=> wb_rsp_o.ack; endproperty
    property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
    property p_dat_zero; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0; endproperty
    property p_oe_len; $fell(flash_o.oe_n) |-> !flash_o.oe_n [*5] ##1 flash_o.oe_n; endproperty
    property p_we_len; $fell(flash_o.we_n) |-> !flash_o.we_n [*2] ##1 flash_o.we_n; endproperty
    property p_gap;
        $rose(flash_o.oe_n) |=> (flash_o.ce_n && flash_o.oe_n) [*4] ##1 flash_o.oe_n;
    endproperty
    property p_rd_bus; !flash_o.oe_n |-> flash_o.dq_oe_n && !flash_o.ce_n; endproperty
    property p_wr_bus; !flash_o.we_n |-> !flash_o.dq_oe_n && !flash_o.ce_n; endproperty
    property p_addr_hold; !(flash_o.oe_n && flash_o.we_n) |-> $stable(flash_o.addr); endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
    a_oe_len: assert property (p_oe_len) else $error("read strobe length");
    a_we_len: assert property (p_we_len) else $error("write strobe length");
    a_gap: assert property (p_gap) else $error("recovery too short");
    a_rd_bus: assert property (p_rd_bus) else $error("bus driven in read");
    a_wr_bus: assert property (p_wr_bus) else $error("bus idle in write");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    c_write: cover property ($fell(flash_o.we_n));
    c_read: cover property ($fell(flash_o.oe_n));
    c_busy: cover property (!flash_i.ready_busy_n && !flash_o.oe_n);
endmodule : fws_poller_sva
bind fws_poller fws_poller_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .flash_i(flash_i), .flash_o(flash_o));

/* sim/fws_flash_model.sv */
// behavioural flash device answering status reads
`timescale 1ns/1ns
module fws_flash_model (
    // host pins
    input wire fws_pkg::fws_flash_out_t pin_i,
    output fws_pkg::fws_flash_in_t pin_o,
    // mode: 0 program, 1 erase, 2 suspended sector, 3 over time limit
    input wire logic [1:0] mode_i,
    input wire logic [7:0] len_i,
    input wire logic prot_i,
    input wire logic clr_i,
    output logic [21:0] last_addr_o
);
    import fws_pkg::*;
    // ****
    // device state
    // ****
    logic [7:0] mem [16];
    logic [7:0] pdata = 8'h00;
    logic [7:0] left = 8'h00;
    logic [7:0] stat;
    logic [7:0] val;
    logic run = 1'b0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic half = 1'b0;
    logic [7:0] arr;
    initial for (int i = 0; i < 16; i++) mem[i] = 8'hff;
    always @(posedge clr_i) run = 1'b0;
    always @(posedge pin_i.we_n) begin
        if (!pin_i.ce_n) begin
            run = 1'b1;
            left = len_i;
            pdata = pin_i.dq;
        end
    end
    always @(negedge pin_i.oe_n) begin
        if (!pin_i.ce_n) begin
            last_addr_o = pin_i.addr;
            half = 1'b0;
            if (run && mode_i != 2'h2) t1 = ~t1;
            if (run && (mode_i == 2'h1 || mode_i == 2'h2)) t2 = ~t2;
            if (run && mode_i < 2'h2 && left <= 8'h1) begin
                run = 1'b0;
                // bit 7 turns true one read ahead of the rest
                half = 1'b1;
                // protected sector keeps its contents
                if (!prot_i) begin
                    mem[pin_i.addr[3:0]] = (mode_i == 2'h0) ? pdata : 8'hff;
                end
            end else if (run) left = left - 8'h1;
        end
    end
    always_comb begin
        case (mode_i)
            2'h1: stat = {1'b0, t1, 2'b00, 1'b1, t2, 2'b00};
            2'h2: stat = {1'b1, t1, 3'h0, t2, 2'b00};
            default: stat = {~pdata[7], t1, mode_i[0], 2'b00, 1'b1, 2'b00};
        endcase
    end
    assign arr = mem[pin_i.addr[3:0]];
    assign val = run ? stat : (half ? {arr[7], stat[6:0]} : arr);
    assign pin_o.dq = (!pin_i.ce_n && !pin_i.oe_n) ? val : ~val;
    assign pin_o.ready_busy_n = !(run && mode_i != 2'h2);
endmodule : fws_flash_model

/* sim/tb.sv */
// testbench: wishbone-driven status polling against a flash model
`timescale 1ns/1ns
module tb;
    import fws_pkg::*;
    // ****
    // harness
    // ****
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    fws_wb_req_t wb_req_i = '0;
    fws_wb_rsp_t wb_rsp_o;
    fws_flash_in_t flash_i;
    fws_flash_out_t flash_o;
    logic [1:0] mode = 2'h0;
    logic clr = 1'b0;
    logic prot = 1'b0;
    logic [21:0] last_addr;
    logic [31:0] rd;
    int fails = 0;
    int total_checks = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    fws_poller dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
        .flash_i(flash_i), .flash_o(flash_o));
    fws_flash_model flash (.pin_i(flash_o), .pin_o(flash_i), .mode_i(mode), .len_i(8'h03),
        .prot_i(prot), .clr_i(clr), .last_addr_o(last_addr));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp_o.ack !== 1'b1 && n < 20);
        rd = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
        if (n >= 20) begin
            check("ack", 32'h0, 32'h1);
            test_done();
        end
    endtask : wb_cycle
    task automatic run_cmd(input logic [2:0] cmd, input logic [21:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_cycle(1'b1, REG_ADDR, {10'h000, a});
        wb_cycle(1'b1, REG_WDATA, {24'h000000, d});
        wb_cycle(1'b1, REG_CTRL, {29'h0, cmd});
        do begin
            wb_cycle(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[SB_BUSY] !== 1'b0 && n < 300);
        if (n >= 300) begin
            check("busy", 32'h1, 32'h0);
            test_done();
        end
    endtask : run_cmd
    task automatic st(input int b, input logic v);
        check($sformatf("status bit %0d", b), {31'h0, rd[b]}, {31'h0, v});
    endtask : st
    task automatic clear_device();
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
    endtask : clear_device
    // ****
    // scenarios
    // ****
    task automatic t_program();
        mode <= 2'h0;
        run_cmd(CMD_WRITE, 22'h000005, 8'h5a);
        run_cmd(CMD_POLL_DATA, 22'h000005, 8'h5a);
        st(SB_DONE, 1'b1);
        st(SB_FAIL, 1'b0);
        st(SB_RB, 1'b1);
        check("poll address", {10'h0, last_addr}, 32'h5);
        wb_cycle(1'b0, REG_RDATA, 32'h0);
        check("rdata", rd, 32'h5a);
        run_cmd(CMD_READ, 22'h000004, 8'h00);
        wb_cycle(1'b0, REG_RDATA, 32'h0);
        check("array read", rd, 32'hff);
        $display("program test ended");
    endtask : t_program
    task automatic t_erase();
        logic [2:0] cmds [2] = '{CMD_POLL_TOGGLE, CMD_POLL_DATA};
        mode <= 2'h1;
        foreach (cmds[i]) begin
            run_cmd(CMD_WRITE, 22'h000005, 8'h00);
            run_cmd(cmds[i], 22'h000005, 8'hff);
            st(SB_DONE, 1'b1);
            st(SB_FAIL, 1'b0);
            check("erase address", {10'h0, last_addr}, 32'h5);
            wb_cycle(1'b0, REG_RDATA, 32'h0);
            check("erased", rd, 32'hff);
        end
        $display("erase test ended");
    endtask : t_erase
    task automatic t_limit();
        logic [2:0] cmds [2] = '{CMD_POLL_DATA, CMD_POLL_TOGGLE};
        mode <= 2'h3;
        foreach (cmds[i]) begin
            run_cmd(CMD_WRITE, 22'h000003, 8'h11);
            run_cmd(cmds[i], 22'h000003, 8'h11);
            st(SB_FAIL, 1'b1);
            st(SB_TLIM, 1'b1);
            st(SB_TGL1, cmds[i] == CMD_POLL_TOGGLE);
            st(SB_TGL2, 1'b0);
            st(SB_EWIN, 1'b0);
            st(SB_RB, 1'b0);
            clear_device();
        end
        $display("time limit test ended");
    endtask : t_limit
    task automatic t_suspend();
        mode <= 2'h2;
        run_cmd(CMD_WRITE, 22'h000007, 8'h00);
        run_cmd(CMD_POLL_TOGGLE, 22'h000007, 8'h00);
        st(SB_DONE, 1'b1);
        st(SB_TGL2, 1'b1);
        st(SB_SUSP, 1'b1);
        st(SB_RB, 1'b1);
        clear_device();
        wb_cycle(1'b1, 8'h20, 32'hffffffff);
        wb_cycle(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        wb_cycle(1'b1, REG_CTRL, {29'h0, CMD_NONE});
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        st(SB_BUSY, 1'b0);
        $display("suspend test ended");
    endtask : t_suspend
    task automatic t_protect();
        logic [1:0] modes [2] = '{2'h0, 2'h1};
        mode <= 2'h0;
        run_cmd(CMD_WRITE, 22'h000009, 8'h33);
        run_cmd(CMD_POLL_DATA, 22'h000009, 8'h33);
        prot <= 1'b1;
        foreach (modes[i]) begin
            mode <= modes[i];
            run_cmd(CMD_WRITE, 22'h000009, 8'hcc);
            run_cmd(CMD_POLL_TOGGLE, 22'h000009, 8'hcc);
            st(SB_DONE, 1'b1);
            st(SB_FAIL, 1'b0);
            wb_cycle(1'b0, REG_RDATA, 32'h0);
            check("protected", rd, 32'h33);
        end
        prot <= 1'b0;
        $display("protect test ended");
    endtask : t_protect
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_program();
        t_erase();
        t_limit();
        t_suspend();
        t_protect();
        test_done();
    end
endmodule : tb
